//--- verilog/rsc_reset_ctrl.v
// Reset source controller: collects reset requests, holds the core and keeps the cause flags.
`timescale 1ns/10ps
`include "rsc_consts.vh"

// Contract
// - In reset the core halts, registers load defaults, pins known, interrupts and timers off.
// - Reset leaves data memory intact but returns the stack pointer to its default.
// - Port latches go to all ones, open-drain, weak pullups on during and after.
// - Power-on or supply monitor reset drives the reset pin low until reset exits.
// - On exit the program counter clears and the clock returns to internal oscillator.
// - After reset the watchdog runs enabled, ticking at system clock divided by twelve.
// - First fetch after release comes from program address zero.
// - Bit 6 read-only, set when a program-memory error caused the last reset.
// - Writing bit 5 enables comparator (active low) reset; reads show comparator cause.
// - Writing one to bit 4 forces reset; read shows software caused last reset.
// - Bit 3 read-only, set when a watchdog overflow caused the last reset.
// - Writing bit 2 enables the missing-clock detector; reads show its timeout cause.
// - Writing bit 1 enables supply monitor as reset source; may reset if it is low.
// - Bit 1 reads one after power-on or supply reset; other flags then undefined.
// - Bit 0 read-only, set for pin reset; bit 7 always reads zero.
module rsc_reset_ctrl
(
    // Clock and power-on reset
    input  wire        clk_sys_i,
    input  wire        reset_i,
    // Reset request sources
    input  wire        rst_pin_n_i,
    input  wire        vdd_low_i,
    input  wire        wdt_overflow_i,
    input  wire        clock_missing_i,
    input  wire        cmp_out_i,
    input  wire        mem_error_i,
    // Special function register port
    input  wire [7:0]  sfr_addr_i,
    input  wire        sfr_wr_i,
    input  wire [7:0]  sfr_wdata_i,
    output reg  [7:0]  sfr_rdata_o,
    // Reset pin drive
    output reg         rst_pin_out_o,
    output reg         rst_pin_oe_o,
    // Core reset controls
    output reg         core_reset_o,
    output reg         sfr_load_default_o,
    output reg         sp_reset_o,
    output reg         irq_timer_disable_o,
    output reg  [7:0]  port_latch_o,
    output reg         port_open_drain_o,
    output reg         weak_pullup_en_o,
    output reg  [15:0] pc_value_o,
    output reg         clk_sel_o,
    output reg         wdt_enable_o,
    output reg         wdt_tick_o
);

    // ======================================================================
    // States
    localparam [2:0] ST_HOLD = 3'b001;
    localparam [2:0] ST_WAIT = 3'b010;
    localparam [2:0] ST_RUN  = 3'b100;

    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg  [3:0] hold_ff;
    reg  [7:0] flags_ff;
    reg  [7:0] nxt_flags;
    reg        cmp_en_ff;
    reg        mcd_en_ff;
    reg        vmon_en_ff;
    reg        vmon_cause_ff;
    reg        start_ff;
    wire       reg_wr;
    wire       div_tick;
    wire       pin_req;
    wire       vmon_req;
    wire       any_req;

    assign reg_wr   = sfr_wr_i && (sfr_addr_i == `RSC_REG_ADDR) && (state_ff == ST_RUN);
    assign pin_req  = ~rst_pin_n_i;
    // A write that enables the monitor while the supply is low resets at once.
    assign vmon_req = vdd_low_i && (vmon_en_ff || (reg_wr && sfr_wdata_i[`RSC_BIT_POR]));
    assign any_req  = pin_req || vmon_req || wdt_overflow_i || mem_error_i
                   || (mcd_en_ff && clock_missing_i)
                   || (cmp_en_ff && ~cmp_out_i)
                   || (reg_wr && sfr_wdata_i[`RSC_BIT_SW]);

    // ======================================================================
    // Cause capture, one flag per reset, highest priority first
    always @*
    begin
        nxt_flags = 8'h00;
        if (vmon_req)
            nxt_flags[`RSC_BIT_POR] = 1'b1;
        else if (pin_req)
            nxt_flags[`RSC_BIT_PIN] = 1'b1;
        else if (mem_error_i)
            nxt_flags[`RSC_BIT_MEMORY_ERROR_FLAG] = 1'b1;
        else if (wdt_overflow_i)
            nxt_flags[`RSC_BIT_WDT] = 1'b1;
        else if (mcd_en_ff && clock_missing_i)
            nxt_flags[`RSC_BIT_MCD] = 1'b1;
        else if (cmp_en_ff && ~cmp_out_i)
            nxt_flags[`RSC_BIT_CMP] = 1'b1;
        else
            nxt_flags[`RSC_BIT_SW] = 1'b1;
    end

    // ======================================================================
    // Sequencer
    always @*
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HOLD:
                if (hold_ff == `RSC_HOLD_CYCLES - 4'h1 && !pin_req)
                    nxt_state = ST_WAIT;
            ST_WAIT:
                nxt_state = pin_req ? ST_HOLD : ST_RUN;
            ST_RUN:
                if (any_req)
                    nxt_state = ST_HOLD;
            default:
                nxt_state = ST_HOLD;
        endcase
    end

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            state_ff      <= ST_HOLD;
            hold_ff       <= 4'h0;
            flags_ff      <= `RSC_FLAGS_RST;
            cmp_en_ff     <= 1'b0;
            mcd_en_ff     <= 1'b0;
            vmon_en_ff    <= 1'b1;
            vmon_cause_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            if (state_ff != ST_HOLD || pin_req)
                hold_ff <= 4'h0;
            else if (hold_ff != `RSC_HOLD_CYCLES - 4'h1)
                hold_ff <= hold_ff + 4'h1;
            if (state_ff == ST_RUN && any_req)
            begin
                flags_ff      <= nxt_flags;
                vmon_cause_ff <= nxt_flags[`RSC_BIT_POR];
                // Enables fall back to defaults; the supply monitor is armed again.
                cmp_en_ff     <= 1'b0;
                mcd_en_ff     <= 1'b0;
                vmon_en_ff    <= 1'b1;
            end
            else if (reg_wr)
            begin
                cmp_en_ff  <= sfr_wdata_i[`RSC_BIT_CMP];
                mcd_en_ff  <= sfr_wdata_i[`RSC_BIT_MCD];
                vmon_en_ff <= sfr_wdata_i[`RSC_BIT_POR];
            end
            if (state_ff == ST_RUN && nxt_state == ST_HOLD)
                vmon_cause_ff <= nxt_flags[`RSC_BIT_POR];
            else if (nxt_state == ST_RUN)
                vmon_cause_ff <= 1'b0;
        end
    end

    // ======================================================================
    // Outputs, all registered
    always @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            sfr_rdata_o         <= 8'h00;
            rst_pin_out_o       <= 1'b0;
            rst_pin_oe_o        <= 1'b1;
            core_reset_o        <= 1'b1;
            sfr_load_default_o  <= 1'b1;
            sp_reset_o          <= 1'b1;
            irq_timer_disable_o <= 1'b1;
            port_latch_o        <= `RSC_PORT_LATCH_RST;
            port_open_drain_o   <= 1'b1;
            weak_pullup_en_o    <= 1'b1;
            pc_value_o          <= `RSC_PC_RST;
            clk_sel_o           <= `RSC_CLKSEL_INTERNAL;
            wdt_enable_o        <= 1'b0;
            start_ff            <= 1'b0;
        end
        else
        begin
            sfr_rdata_o   <= (sfr_addr_i == `RSC_REG_ADDR) ? {1'b0, flags_ff[6:0]} : 8'h00;
            rst_pin_out_o <= 1'b0;
            // On entry the cause is taken from the request itself, so the pin drives from the first reset cycle.
            rst_pin_oe_o  <= (nxt_state != ST_RUN) && ((state_ff == ST_RUN) ? nxt_flags[`RSC_BIT_POR] : vmon_cause_ff);
            core_reset_o        <= (nxt_state != ST_RUN);
            sfr_load_default_o  <= (nxt_state != ST_RUN);
            sp_reset_o          <= (nxt_state != ST_RUN);
            irq_timer_disable_o <= (nxt_state != ST_RUN);
            weak_pullup_en_o    <= 1'b1;
            if (nxt_state != ST_RUN)
            begin
                port_latch_o      <= `RSC_PORT_LATCH_RST;
                port_open_drain_o <= 1'b1;
                pc_value_o        <= `RSC_PC_RST;
                clk_sel_o         <= `RSC_CLKSEL_INTERNAL;
            end
            start_ff     <= (nxt_state == ST_RUN);
            wdt_enable_o <= (nxt_state == ST_RUN);
        end
    end

    // ======================================================================
    // Watchdog clock divider, restarted on every reset
    rsc_wdt_div rsc_wdt_div_inst
    (
        .clk_sys_i (clk_sys_i),
        .clear_i   (reset_i || !start_ff),
        .tick_o    (div_tick)
    );

    always @(posedge clk_sys_i)
    begin
        if (reset_i)
            wdt_tick_o <= 1'b0;
        else
            wdt_tick_o <= div_tick && start_ff;
    end

endmodule

//--- verilog/rsc_consts.vh
// Constants for the reset source controller: register layout, reset values and timing counts.
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH
// ==========================================================================
// Register map
`define RSC_REG_ADDR        8'hef
`define RSC_BIT_MEMORY_ERROR_FLAG      6
`define RSC_BIT_CMP         5
`define RSC_BIT_SW          4
`define RSC_BIT_WDT         3
`define RSC_BIT_MCD         2
`define RSC_BIT_POR         1
`define RSC_BIT_PIN         0
// ==========================================================================
// Reset values driven into the core
`define RSC_PORT_LATCH_RST  8'hff
`define RSC_PC_RST          16'h0000
`define RSC_CLKSEL_INTERNAL 1'b0
`define RSC_FLAGS_RST       8'h02
// ==========================================================================
// Timing
`define RSC_WDT_DIV         4'hc
`define RSC_HOLD_CYCLES     4'h8
`endif

//--- verilog/rsc_wdt_div.v
// Divide-by-twelve enable generator that clocks the watchdog after reset.
`timescale 1ns/10ps
`include "rsc_consts.vh"

module rsc_wdt_div
(
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       clear_i,
    // Tick output
    output reg        tick_o
);

    reg  [3:0] count_ff;

    // ======================================================================
    // Divider
    always @(posedge clk_sys_i)
    begin
        if (clear_i)
        begin
            count_ff <= 4'h0;
            tick_o   <= 1'b0;
        end
        else if (count_ff == `RSC_WDT_DIV - 4'h1)
        begin
            count_ff <= 4'h0;
            tick_o   <= 1'b1;
        end
        else
        begin
            count_ff <= count_ff + 4'h1;
            tick_o   <= 1'b0;
        end
    end

endmodule

//--- verification/rsc_reset_ctrl_properties.sv
// Port assertions for the reset source controller.
`timescale 1ns/10ps
module rsc_reset_ctrl_properties
(
    // Clock and reset
    input wire logic        clk_sys_i,
    input wire logic        reset_i,
    // Requests and register port
    input wire logic        rst_pin_n_i,
    input wire logic        sfr_wr_i,
    input wire logic [7:0]  sfr_addr_i,
    input wire logic [7:0]  sfr_wdata_i,
    input wire logic [7:0]  sfr_rdata_o,
    // Core controls
    input wire logic        core_reset_o,
    input wire logic        sp_reset_o,
    input wire logic        rst_pin_oe_o,
    input wire logic [7:0]  port_latch_o,
    input wire logic        weak_pullup_en_o,
    input wire logic [15:0] pc_value_o,
    input wire logic        wdt_enable_o,
    input wire logic        wdt_tick_o
);
    // ==========================================
    // Properties
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    // Eleven quiet cycles lie between two watchdog ticks.
    sequence wdt_quiet;
        (!wdt_tick_o)[*8] ##1 (!wdt_tick_o)[*3];
    endsequence

    pin_hold_a: assert property (!rst_pin_n_i |-> ##[1:3] core_reset_o)
        else $error("core not held while reset pin low");
    sw_force_a: assert property (sfr_wr_i && sfr_addr_i == 8'hef && sfr_wdata_i[4] && !core_reset_o
        |-> ##[1:2] core_reset_o) else $error("software force did not reset");
    hold_length_a: assert property ($rose(core_reset_o) |-> core_reset_o[*8])
        else $error("reset hold too short");
    stack_reset_a: assert property (sp_reset_o == core_reset_o)
        else $error("stack pointer reset not tied to core reset");
    port_ones_a: assert property (core_reset_o |-> port_latch_o == 8'hff && weak_pullup_en_o)
        else $error("port latches not all ones in reset");
    exit_state_a: assert property ($fell(core_reset_o) |-> pc_value_o == 16'h0000 && wdt_enable_o)
        else $error("bad state on reset exit");
    wdt_gap_a: assert property (@(posedge clk_sys_i) disable iff (reset_i || core_reset_o)
        wdt_tick_o |=> wdt_quiet ##1 wdt_tick_o) else $error("watchdog tick spacing wrong");
    bit7_zero_a: assert property (sfr_rdata_o[7] == 1'h0)
        else $error("read data bit 7 not zero");
    pin_drive_a: assert property (rst_pin_oe_o |-> core_reset_o)
        else $error("reset pin driven outside reset");
endmodule

bind rsc_reset_ctrl rsc_reset_ctrl_properties rsc_reset_ctrl_properties_inst
(
    .clk_sys_i, .reset_i, .rst_pin_n_i, .sfr_wr_i, .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .rst_pin_oe_o,
    .core_reset_o, .sp_reset_o, .port_latch_o, .weak_pullup_en_o, .pc_value_o, .wdt_enable_o, .wdt_tick_o
);

//--- verification/rsc_reset_ctrl_tb_top.sv
// Self-checking bench for the reset source controller.
`timescale 1ns/10ps
`include "rsc_consts.vh"
module rsc_reset_ctrl_tb_top;
    logic        clk_sys_i = 1'h0, reset_i = 1'h1, rst_pin_n_i = 1'h1, vdd_low_i = 1'h0, sfr_wr_i = 1'h0;
    logic        wdt_overflow_i = 1'h0, clock_missing_i = 1'h0, cmp_out_i = 1'h1, mem_error_i = 1'h0;
    logic        rst_pin_out_o, rst_pin_oe_o, core_reset_o, sfr_load_default_o, sp_reset_o, clk_sel_o;
    logic        irq_timer_disable_o, port_open_drain_o, weak_pullup_en_o, wdt_enable_o, wdt_tick_o;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, port_latch_o, last;
    logic [15:0] pc_value_o;
    logic [31:0] lfsr = 32'h732f;
    int          n_fail = 0, checks = 0, cyc = 0, n, i, len, k;

    rsc_reset_ctrl rsc_reset_ctrl_inst
    (
        .clk_sys_i, .reset_i, .rst_pin_n_i, .vdd_low_i, .wdt_overflow_i, .clock_missing_i, .cmp_out_i,
        .mem_error_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rdata_o, .rst_pin_out_o, .rst_pin_oe_o,
        .core_reset_o, .sfr_load_default_o, .sp_reset_o, .irq_timer_disable_o, .port_latch_o,
        .port_open_drain_o, .weak_pullup_en_o, .pc_value_o, .clk_sel_o, .wdt_enable_o, .wdt_tick_o
    );

    // ==========================================
    // Helpers
    always #5 clk_sys_i = ~clk_sys_i;

    // A hung wait anywhere ends the run as a failure.
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_fail++;
            conclude();
        end
    end

    function automatic [31:0] lfsr_step(input [31:0] s);
        lfsr_step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Source codes equal the bit position of their cause flag.
    function automatic [7:0] exp_flags(input [2:0] src);
        exp_flags = 8'h01 << src;
    endfunction

    task automatic conclude;
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input [23:0] exp, input [23:0] got);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input [7:0] a, input [7:0] d);
        @(negedge clk_sys_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = 1'h1;
        @(negedge clk_sys_i);
        sfr_wr_i = 1'h0;
    endtask

    task automatic run_reset(input [2:0] src, input int low_len);
        n = 0;
        for (i = 0; i < 4 && core_reset_o !== 1'h1; i++) @(negedge clk_sys_i);
        while (core_reset_o === 1'h1 && n < 300)
        begin
            @(negedge clk_sys_i);
            n++;
            if (n == 2)
                chk("in reset", {src == 3'h1, 9'h0ff, 4'hf}, {rst_pin_oe_o, rst_pin_out_o, port_latch_o,
                    port_open_drain_o, weak_pullup_en_o, sfr_load_default_o, irq_timer_disable_o});
            if (n == low_len) rst_pin_n_i = 1'h1;
        end
        chk("hold", 1'h1, n == low_len + `RSC_HOLD_CYCLES + 1);
        chk("exit", 22'h000001, {pc_value_o, clk_sel_o, rst_pin_oe_o, sfr_load_default_o,
            sp_reset_o, irq_timer_disable_o, wdt_enable_o});
        last = exp_flags(src);
        @(negedge clk_sys_i);
        sfr_addr_i = `RSC_REG_ADDR;
        @(negedge clk_sys_i);
        chk("flags", last, sfr_rdata_o);
    endtask

    task automatic trigger(input [2:0] src);
        len = 0;
        if (src == 3'h2 || src == 3'h5) wr(`RSC_REG_ADDR, exp_flags(src));
        if (src == 3'h1)
        begin
            wr(`RSC_REG_ADDR, 8'h00);
            vdd_low_i = 1'h1;
            repeat (3) @(negedge clk_sys_i);
            chk("monitor off", 1'h0, core_reset_o);
            wr(`RSC_REG_ADDR, 8'h02);
            vdd_low_i = 1'h0;
        end
        else if (src == 3'h4)
            wr(`RSC_REG_ADDR, 8'h10);
        else
        begin
            @(negedge clk_sys_i);
            rst_pin_n_i = (src != 3'h0);
            wdt_overflow_i = (src == 3'h3);
            clock_missing_i = (src == 3'h2);
            cmp_out_i = (src != 3'h5);
            mem_error_i = (src == 3'h6);
            len = (src == 3'h0) ? 10 + lfsr[3:0] : 0;
            @(negedge clk_sys_i);
            {wdt_overflow_i, clock_missing_i, mem_error_i, cmp_out_i} = 4'h1;
        end
        run_reset(src, len);
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        repeat (20) @(negedge clk_sys_i);
        reset_i = 1'h0;
        run_reset(3'h1, 0);
        for (k = 0; k < 18; k++)
        begin
            lfsr = lfsr_step(lfsr);
            trigger((k < 7) ? k[2:0] : lfsr[4:2] % 3'h7);
        end
        // The monitor is armed again by the last reset, so a low supply alone must reset.
        @(negedge clk_sys_i);
        vdd_low_i = 1'h1;
        @(negedge clk_sys_i);
        vdd_low_i = 1'h0;
        run_reset(3'h1, 0);
        trigger(3'h3);
        wr({1'h0, lfsr[6:0]}, 8'h10);
        wr(`RSC_REG_ADDR, 8'hc9);
        @(negedge clk_sys_i);
        clock_missing_i = 1'h1;
        repeat (3) @(negedge clk_sys_i);
        clock_missing_i = 1'h0;
        chk("no reset", 1'h0, core_reset_o);
        sfr_addr_i = `RSC_REG_ADDR;
        @(negedge clk_sys_i);
        chk("flags kept", last, sfr_rdata_o);
        for (i = 0; i < 30 && wdt_tick_o !== 1'h1; i++) @(negedge clk_sys_i);
        n = 0;
        do
        begin
            @(negedge clk_sys_i);
            n++;
        end while (wdt_tick_o !== 1'h1 && n < 30);
        chk("tick gap", 24'h00000c, n);
        conclude();
    end
endmodule
